/* File: hw/jump_minus_exec.sv */
// Overview of operation
// - condition field is opcode bits 7:4, selecting one of sixteen flag tests.
// - both jump forms test only carry, zero, sign and overflow flags.
// - jump taken only when test is true, else continue sequentially.
// - code 0 never true; 1 is s xor v; 2 is z or (s xor v).
// - opcodes 32-37 store dst minus src minus carry; update c,z,s,v,h; set d.
// - opcodes 38 and 39 do wide minus-with-borrow with identical flag effects.
// - opcodes 22-27 store dst minus src; update c,z,s,v,h; set d.
`timescale 1ns/1ns
`default_nettype none
module jump_minus_exec
  import exec_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_op_valid,
  input wire logic [DATA_W-1:0] i_opcode,
  input wire logic [DATA_W-1:0] i_dst,
  input wire logic [DATA_W-1:0] i_src,
  input wire logic [ADDR_W-1:0] i_pc_seq,
  input wire logic [ADDR_W-1:0] i_abs_target,
  input wire logic [DATA_W-1:0] i_rel_disp,
  input wire logic i_flags_we,
  input wire logic [FLAG_W-1:0] i_flags,
  output logic o_done,
  output logic o_result_we,
  output logic [DATA_W-1:0] o_result,
  output logic o_pc_load,
  output logic [ADDR_W-1:0] o_next_pc,
  output logic o_jump_taken,
  output logic [FLAG_W-1:0] o_flags
);
  function automatic logic in_range(input logic [3:0] nib, input logic [3:0] lo,
                                    input logic [3:0] hi);
    in_range = (nib >= lo) && (nib <= hi);
  endfunction : in_range

  logic done_q;
  logic result_we_q;
  logic [DATA_W-1:0] result_q;
  logic [DATA_W-1:0] result_d;
  logic pc_load_q;
  logic [ADDR_W-1:0] next_pc_q;
  logic [ADDR_W-1:0] next_pc_d;
  logic taken_q;
  logic [FLAG_W-1:0] flags_q;
  logic [FLAG_W-1:0] flags_d;
  op_kind_t kind;

  // decode
  wire logic [3:0] row = i_opcode[COND_HI:COND_LO];
  wire logic [3:0] nib = i_opcode[NIB_HI:NIB_LO];
  wire logic [3:0] condition_field = i_opcode[COND_HI:COND_LO];
  wire logic relative_jump = (nib == NIB_REL_JUMP);
  wire logic absolute_jump = (nib == NIB_ABS_JUMP);
  wire logic sub_form = in_range(nib, NIB_SHORT_FIRST, NIB_SHORT_LAST) |
                        in_range(nib, NIB_WIDE_FIRST, NIB_WIDE_LAST);
  wire logic is_minus = (row == ROW_MINUS) && sub_form;
  wire logic is_minus_borrow = (row == ROW_MINUS_BORROW) && sub_form;

  always_comb begin
    if (relative_jump || absolute_jump) begin
      kind = OP_JUMP;
    end else if (is_minus) begin
      kind = OP_MINUS;
    end else if (is_minus_borrow) begin
      kind = OP_MINUS_BORROW;
    end else begin
      kind = OP_NONE;
    end
  end

  // condition test
  wire logic cond_true;
  cond_eval u_cond (
    .i_condition_field(condition_field),
    .i_c(flags_q[FLAG_C]),
    .i_z(flags_q[FLAG_Z]),
    .i_s(flags_q[FLAG_S]),
    .i_v(flags_q[FLAG_V]),
    .o_true(cond_true)
  );

  // relative displacement is signed, sign-extended to the address width
  wire logic [ADDR_W-1:0] rel_ext = {{(ADDR_W-DATA_W){i_rel_disp[DATA_W-1]}}, i_rel_disp};
  wire logic [ADDR_W-1:0] rel_target = i_pc_seq + rel_ext;
  wire logic [ADDR_W-1:0] jump_target = relative_jump ? rel_target : i_abs_target;

  // subtraction datapath; borrow-in only for the borrow forms
  wire logic borrow_in = (kind == OP_MINUS_BORROW) ? flags_q[FLAG_C] : 1'b0;
  wire logic [DATA_W:0] diff = {1'b0, i_dst} - {1'b0, i_src} - {{DATA_W{1'b0}}, borrow_in};
  wire logic [4:0] half_diff = {1'b0, i_dst[3:0]} - {1'b0, i_src[3:0]} - {4'h0, borrow_in};
  wire logic [DATA_W-1:0] diff_byte = diff[DATA_W-1:0];
  wire logic sub_c = diff[DATA_W];
  wire logic sub_z = (diff_byte == {DATA_W{1'b0}});
  wire logic sub_s = diff_byte[DATA_W-1];
  // overflow: operands of opposite sign and result sign differs from dst
  wire logic sub_v = (i_dst[DATA_W-1] ^ i_src[DATA_W-1]) &
                     (diff_byte[DATA_W-1] ^ i_dst[DATA_W-1]);
  wire logic sub_h = half_diff[4];

  always_comb begin
    flags_d = flags_q;
    result_d = result_q;
    next_pc_d = next_pc_q;
    if (i_op_valid && (kind == OP_MINUS || kind == OP_MINUS_BORROW)) begin
      flags_d[FLAG_C] = sub_c;
      flags_d[FLAG_Z] = sub_z;
      flags_d[FLAG_S] = sub_s;
      flags_d[FLAG_V] = sub_v;
      flags_d[FLAG_D] = 1'b1;
      flags_d[FLAG_H] = sub_h;
      result_d = diff_byte;
    end else if (i_op_valid && kind == OP_JUMP) begin
      // jumps leave every flag alone
      next_pc_d = cond_true ? jump_target : i_pc_seq;
    end else if (i_flags_we) begin
      // external load loses to an executing instruction in the same cycle
      flags_d = i_flags;
    end
  end

  wire logic exec_sub = i_op_valid && (kind == OP_MINUS || kind == OP_MINUS_BORROW);
  wire logic exec_jump = i_op_valid && (kind == OP_JUMP);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      done_q <= 1'b0;
      result_we_q <= 1'b0;
      pc_load_q <= 1'b0;
      taken_q <= 1'b0;
    end else begin
      done_q <= exec_sub | exec_jump;
      result_we_q <= exec_sub;
      pc_load_q <= exec_jump;
      taken_q <= exec_jump & cond_true;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      result_q <= {DATA_W{1'b0}};
      next_pc_q <= {ADDR_W{1'b0}};
      flags_q <= FLAGS_RESET;
    end else begin
      result_q <= result_d;
      next_pc_q <= next_pc_d;
      flags_q <= flags_d;
    end
  end

  assign o_done = done_q;
  assign o_result_we = result_we_q;
  assign o_result = result_q;
  assign o_pc_load = pc_load_q;
  assign o_next_pc = next_pc_q;
  assign o_jump_taken = taken_q;
  assign o_flags = flags_q;
endmodule : jump_minus_exec
`default_nettype wire

/* File: hw/cond_eval.sv */
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int FLAG_W = 6;
  // flag vector bit positions
  localparam int FLAG_C = 5;
  localparam int FLAG_Z = 4;
  localparam int FLAG_S = 3;
  localparam int FLAG_V = 2;
  localparam int FLAG_D = 1;
  localparam int FLAG_H = 0;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h00;
  // opcode fields
  localparam int COND_HI = 7;
  localparam int COND_LO = 4;
  localparam int NIB_HI = 3;
  localparam int NIB_LO = 0;
  localparam logic [3:0] NIB_REL_JUMP = 4'hb;
  localparam logic [3:0] NIB_ABS_JUMP = 4'hd;
  localparam logic [3:0] ROW_MINUS = 4'h2;
  localparam logic [3:0] ROW_MINUS_BORROW = 4'h3;
  localparam logic [3:0] NIB_SHORT_FIRST = 4'h2;
  localparam logic [3:0] NIB_SHORT_LAST = 4'h7;
  localparam logic [3:0] NIB_WIDE_FIRST = 4'h8;
  localparam logic [3:0] NIB_WIDE_LAST = 4'h9;
  // condition field encodings
  localparam logic [3:0] CC_NEVER = 4'h0;
  localparam logic [3:0] CC_SIGNED_BELOW = 4'h1;
  localparam logic [3:0] CC_SIGNED_BELOW_OR_EQUAL = 4'h2;
  localparam logic [3:0] CC_UNSIGNED_BELOW_OR_EQUAL = 4'h3;
  localparam logic [3:0] CC_OVERFLOW = 4'h4;
  localparam logic [3:0] CC_MINUS = 4'h5;
  localparam logic [3:0] CC_ZERO = 4'h6;
  localparam logic [3:0] CC_CARRY = 4'h7;
  localparam logic [3:0] CC_COMPLEMENT_BIT = 4'h8;
  localparam int CC_SEL_HI = 2;
  localparam int CC_SEL_LO = 0;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_JUMP,
    OP_MINUS,
    OP_MINUS_BORROW
  } op_kind_t;
endpackage : exec_pkg

`timescale 1ns/1ns
`default_nettype none
module cond_eval
  import exec_pkg::*;
(
  input wire logic [3:0] i_condition_field,
  input wire logic i_c,
  input wire logic i_z,
  input wire logic i_s,
  input wire logic i_v,
  output logic o_true
);
  // codes 8..f are the complements of codes 0..7
  wire logic [2:0] base_sel = i_condition_field[CC_SEL_HI:CC_SEL_LO];
  wire logic invert = i_condition_field[COND_HI-COND_LO];
  wire logic signed_below = i_s ^ i_v;
  logic base_true;

  always_comb begin
    case ({1'b0, base_sel})
      CC_NEVER: base_true = 1'b0;
      CC_SIGNED_BELOW: base_true = signed_below;
      CC_SIGNED_BELOW_OR_EQUAL: base_true = i_z | signed_below;
      CC_UNSIGNED_BELOW_OR_EQUAL: base_true = i_c | i_z;
      CC_OVERFLOW: base_true = i_v;
      CC_MINUS: base_true = i_s;
      CC_ZERO: base_true = i_z;
      CC_CARRY: base_true = i_c;
      default: base_true = 1'b0;
    endcase
  end

  // only c, z, s and v feed the test
  assign o_true = base_true ^ invert;
endmodule : cond_eval
`default_nettype wire

/* File: verif/jump_minus_exec_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module jump_minus_exec_chk
  import exec_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_op_valid,
  input wire logic [DATA_W-1:0] i_opcode,
  input wire logic [DATA_W-1:0] i_dst,
  input wire logic [DATA_W-1:0] i_src,
  input wire logic o_done,
  input wire logic o_result_we,
  input wire logic [DATA_W-1:0] o_result,
  input wire logic o_pc_load,
  input wire logic o_jump_taken,
  input wire logic [FLAG_W-1:0] o_flags
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire logic [3:0] hi = i_opcode[7:4];
  wire logic [3:0] lo = i_opcode[3:0];
  wire logic jmp = i_op_valid && (lo == NIB_REL_JUMP || lo == NIB_ABS_JUMP);
  wire logic sub = i_op_valid && (hi == ROW_MINUS || hi == ROW_MINUS_BORROW)
    && lo >= NIB_SHORT_FIRST && lo <= NIB_WIDE_LAST;
  wire logic [7:0] diff = i_dst - i_src;
  // borrow taken from the flag value before this edge
  wire logic [7:0] diff_b = diff - {7'h00, o_flags[FLAG_C]};
  AST_DONE: assert property ((jmp || sub) |=> o_done && o_result_we == $past(sub))
    else $error("done or result strobe wrong");
  AST_IDLE: assert property (!(jmp || sub) |=> !o_done && !o_pc_load && !o_result_we)
    else $error("strobe without accepted op");
  AST_SUB: assert property ((sub && hi == ROW_MINUS) |=> o_result == $past(diff)
    && o_flags[FLAG_C] == $past(i_dst < i_src)) else $error("plain difference wrong");
  AST_SBC: assert property ((sub && hi == ROW_MINUS_BORROW) |=> o_result == $past(diff_b))
    else $error("borrow difference wrong");
  AST_DSET: assert property (sub |=> o_flags[FLAG_D])
    else $error("decimal flag not set");
  AST_ZS: assert property (sub |=> o_flags[FLAG_Z] == (o_result == 8'h00)
    && o_flags[FLAG_S] == o_result[7]) else $error("zero or sign flag wrong");
  AST_NEVER: assert property ((jmp && hi == CC_NEVER) |=> o_pc_load && !o_jump_taken)
    else $error("never code taken");
  AST_BELOW: assert property ((jmp && hi == CC_SIGNED_BELOW)
    |=> o_jump_taken == $past(o_flags[FLAG_S] ^ o_flags[FLAG_V])) else $error("below test wrong");
  AST_KEEP: assert property (jmp |=> $stable(o_flags))
    else $error("jump changed flags");
  cover property (sub ##1 jmp);
  cover property (jmp ##1 o_jump_taken);
  cover property (sub && hi == ROW_MINUS_BORROW);
endmodule : jump_minus_exec_chk
bind jump_minus_exec jump_minus_exec_chk chk_u (.i_clk, .i_rst, .i_op_valid, .i_opcode, .i_dst,
  .i_src, .o_done, .o_result_we, .o_result, .o_pc_load, .o_jump_taken, .o_flags);
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import exec_pkg::*;
  logic i_clk = 0, i_rst = 1, i_op_valid = 0, i_flags_we = 0, o_done, o_result_we;
  logic o_pc_load, o_jump_taken;
  logic [7:0] i_opcode = 0, i_dst = 0, i_src = 0, o_result;
  logic [15:0] o_next_pc;
  logic [5:0] i_flags = 0, o_flags;
  int bad_count = 0, tests_run = 0;
  jump_minus_exec dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_op_valid(i_op_valid),
    .i_opcode(i_opcode), .i_dst(i_dst), .i_src(i_src), .i_pc_seq(16'h0100),
    .i_abs_target(16'h1234), .i_rel_disp(8'hfe), .i_flags_we(i_flags_we), .i_flags(i_flags),
    .o_done(o_done), .o_result_we(o_result_we), .o_result(o_result), .o_pc_load(o_pc_load),
    .o_next_pc(o_next_pc), .o_jump_taken(o_jump_taken), .o_flags(o_flags));
  initial forever #25 i_clk = ~i_clk;
  task automatic results();
    $display("mismatches %0d of %0d checks", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (!ok) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic setf(input logic [5:0] f);
    @(posedge i_clk) #1;
    i_flags_we = 1;
    i_flags = f;
    @(posedge i_clk) #1;
    i_flags_we = 0;
  endtask : setf
  // one cycle of valid, outputs looked at once that edge has landed
  task automatic op(input logic [7:0] opc, input logic [7:0] d, input logic [7:0] s);
    @(posedge i_clk) #1;
    i_op_valid = 1;
    i_opcode = opc;
    i_dst = d;
    i_src = s;
    @(posedge i_clk) #1;
    i_op_valid = 0;
  endtask : op
  function automatic logic cexp(input logic [3:0] c, input logic [5:0] f);
    logic r;
    case (c[2:0])
      3'h0: r = 1'b0;
      3'h1: r = f[FLAG_S] ^ f[FLAG_V];
      3'h2: r = f[FLAG_Z] | (f[FLAG_S] ^ f[FLAG_V]);
      3'h3: r = f[FLAG_C] | f[FLAG_Z];
      3'h4: r = f[FLAG_V];
      3'h5: r = f[FLAG_S];
      3'h6: r = f[FLAG_Z];
      default: r = f[FLAG_C];
    endcase
    return r ^ c[3];
  endfunction : cexp
  task automatic t_jump(input logic [5:0] f);
    logic t;
    setf(f);
    for (int c = 0; c < 16; c++) begin
      t = cexp(c[3:0], f);
      op({c[3:0], c[0] ? NIB_ABS_JUMP : NIB_REL_JUMP}, 8'h00, 8'h00);
      chk(o_pc_load === 1'b1 && o_jump_taken === t, "jump decision");
      chk(o_next_pc === (!t ? 16'h0100 : c[0] ? 16'h1234 : 16'h00fe), "next pc");
      chk(o_flags === f, "flags moved");
    end
  endtask : t_jump
  task automatic t_sub();
    op(8'h22, 8'h05, 8'h07);
    chk(o_result_we === 1'b1 && o_result === 8'hfe && o_flags === 6'h2b, "sub");
    op(8'h29, 8'h80, 8'h01);
    chk(o_result === 8'h7f && o_flags === 6'h07, "wide sub");
  endtask : t_sub
  task automatic t_sbc();
    setf(6'h20);
    op(8'h34, 8'h10, 8'h0f);
    chk(o_result === 8'h00 && o_flags === 6'h13, "borrow sub");
    op(8'h38, 8'h03, 8'h01);
    chk(o_result === 8'h02 && o_flags === 6'h02, "wide borrow clear");
    setf(6'h20);
    op(8'h39, 8'h03, 8'h01);
    chk(o_result === 8'h01 && o_flags === 6'h02, "wide borrow set");
  endtask : t_sbc
  // a flag load in the same cycle as a subtract must lose to it
  task automatic t_race();
    @(posedge i_clk) #1;
    i_op_valid = 1;
    i_opcode = 8'h22;
    i_dst = 8'h05;
    i_src = 8'h07;
    i_flags_we = 1;
    i_flags = 6'h15;
    @(posedge i_clk) #1;
    i_op_valid = 0;
    i_flags_we = 0;
    chk(o_done === 1'b1 && o_result === 8'hfe && o_flags === 6'h2b, "flag load won");
  endtask : t_race
  task automatic t_ref();
    setf(6'h15);
    op(8'h2a, 8'h01, 8'h02);
    chk(o_done === 1'b0 && o_flags === 6'h15, "unknown opcode acted");
  endtask : t_ref
  initial begin
    #20000;
    bad_count++;
    results();
  end
  initial begin
    repeat (2) @(posedge i_clk);
    #1 i_rst = 0;
    t_sub();
    t_sbc();
    t_jump(6'h08);
    t_jump(6'h3c);
    t_ref();
    t_race();
    results();
  end
endmodule : tb_top
`default_nettype wire
